// ### bench/board_straps.sv
// Board strap resistors and status LEDs on the shared pins.
`timescale 1ns/1ns
`default_nettype none
module board_straps
(
  // Strap pattern set by the resistors.
  input  wire logic [4:0] strap,
  // Device side of the pins.
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  output logic      [4:0] pin_in
);
  // Every pin has a resistor, so a released pin reads its strap and never floats.
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & strap);
endmodule : board_straps
`default_nettype wire

// ### bench/phy_address_strap_led_pins_tb_top.sv
// Self-checking bench for the shared strap and LED pins.
`timescale 1ns/1ns
`default_nettype none
module phy_address_strap_led_pins_tb_top;
  import strap_led_pkg::*;
  localparam int HOLD = 20;
  logic       clock = 1'b0;
  logic       hardware_reset_n = 1'b0;
  logic       soft_reset = 1'b0;
  logic       clk_en = 1'b1;
  status_t    status = '0;
  logic [4:0] frame_addr = 5'h00;
  logic [4:0] strap = 5'h0b;
  logic [4:0] pin_in, pin_out, pin_oe, mgmt;
  logic       addr_match, strap_valid;
  int         bad_count = 0;
  int         checks = 0;
  // Rows of status beside the LED lit pattern they should give.
  logic [3:0] row_st [7] = '{4'h0, 4'h8, 4'h4, 4'hc, 4'h1, 4'hd, 4'h5};
  logic [4:0] row_on [7] = '{5'h00, 5'h11, 5'h09, 5'h19, 5'h04, 5'h1d, 5'h0d};

  always #20 clock = ~clock;

  strap_led_pins #(.HOLD_CYC(HOLD)) i_dut (.clock(clock), .hardware_reset_n(hardware_reset_n),
    .clk_en(clk_en), .soft_reset(soft_reset), .status(status), .frame_addr(frame_addr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .management_address(mgmt),
    .addr_match(addr_match), .strap_valid(strap_valid));
  board_straps i_board (.strap(strap), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  // Compares one pin or address vector; a single flag goes in bit 0.
  task automatic cmp(input logic [4:0] got, input logic [4:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Compares one flag.
  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_bit

  task automatic test_done;
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  // Hardware reset with a new strap; the pins must be released in reset and all drive after it.
  task automatic hw_reset(input logic [4:0] s);
    strap = s;
    hardware_reset_n = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    cmp(pin_oe, 5'h00);
    cmp_bit(strap_valid, 1'b0);
    cmp_bit(addr_match, 1'b0);
    hardware_reset_n = 1'b1;
    repeat (10) @(posedge clock);
    #1;
    cmp(mgmt, s);
    cmp_bit(strap_valid, 1'b1);
    cmp(pin_oe, 5'h1f);
    cmp(pin_out, s);
  endtask : hw_reset

  task automatic step_check(input logic [3:0] st, input logic [4:0] on);
    status = st;
    @(posedge clock);
    #1;
    @(posedge clock);
    #1;
    cmp(pin_out, mgmt ^ on);
  endtask : step_check

  initial
  begin
    hw_reset(5'h0b);
    frame_addr = 5'h0b;
    @(posedge clock);
    #1;
    cmp_bit(addr_match, 1'b1);
    frame_addr = 5'h0a;
    @(posedge clock);
    #1;
    cmp_bit(addr_match, 1'b0);
    for (int i = 0; i < 7; i++)
      step_check(row_st[i], row_on[i]);
    // One-cycle collision lights the LED for exactly the hold count, then drops.
    status = 4'h2;
    @(posedge clock);
    #1;
    status = 4'h0;
    @(posedge clock);
    #1;
    cmp(pin_out, 5'h09);
    repeat (HOLD - 1) @(posedge clock);
    #1;
    cmp(pin_out, 5'h09);
    @(posedge clock);
    #1;
    cmp(pin_out, 5'h0b);
    // Software reset with changed straps must leave address and drivers alone.
    strap = 5'h14;
    soft_reset = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    soft_reset = 1'b0;
    cmp(mgmt, 5'h0b);
    cmp(pin_oe, 5'h1f);
    // Clock enable low freezes the LED drive although the link comes up.
    clk_en = 1'b0;
    status = 4'h1;
    repeat (3) @(posedge clock);
    #1;
    cmp(pin_out, 5'h0b);
    clk_en = 1'b1;
    @(posedge clock);
    #1;
    cmp(pin_out, 5'h0f);
    status = 4'h0;
    hw_reset(5'h14);
    step_check(4'h1, 5'h04);
    test_done;
  end

  // Watchdog well past the 88 cycles the sequence needs.
  initial
  begin
    repeat (3000) @(posedge clock);
    bad_count++;
    test_done;
  end
endmodule : phy_address_strap_led_pins_tb_top
`default_nettype wire

// ### inc/strap_led_map.svh
// Constants for the shared strap and LED pin block.
`ifndef STRAP_LED_MAP_SVH
`define STRAP_LED_MAP_SVH
`define PIN_COUNT         5
`define ADDR_BIT_ACT      0
`define ADDR_BIT_COL      1
`define ADDR_BIT_LINK     2
`define ADDR_BIT_TX       3
`define ADDR_BIT_RX       4
`define CLOCK_HZ          25000000
`define COL_STRETCH_MS    70
`define COL_STRETCH_CYC   ((`CLOCK_HZ / 1000) * `COL_STRETCH_MS)
`define CNT_W             21
`define FILL_LAST         3'h3
`endif

// ### inc/strap_led_pkg.sv
// Types shared by the strap and LED pin block.
package strap_led_pkg;
  typedef enum logic [1:0] {ST_RESET, ST_SAMPLE, ST_RUN} phase_t;
  typedef struct packed
  {
    logic rx_active;
    logic tx_active;
    logic collision;
    logic link_up;
  } status_t;
  typedef struct packed
  {
    logic [4:0] in_lvl;
    logic [4:0] out_lvl;
    logic [4:0] out_en;
  } pins_t;
endpackage : strap_led_pkg

// ### rtl/strap_led_pins.sv
// Shared address strap and status LED pins of the PHY.
// Notes on behaviour
// - In hardware reset pins are inputs; levels are sampled as reset ends.
// - Activity pin gives address bit 0, then drives activity LED.
// - Sampled low loads zero, sampled high loads one.
// - Activity LED lit on receive or transmit activity.
// - Collision pin gives address bit 1, then drives collision LED.
// - Collision LED held about 70 ms after a collision.
// - Link pin gives address bit 2, then drives link LED.
// - Link LED lit while link is valid.
// - Transmit pin gives address bit 3, then drives transmit LED.
// - Transmit LED lit while transmitting.
// - LED asserted level is inverse of the sampled strap level.
// - Software reset neither resamples nor turns pins into inputs.
// - Fifth pin gives address bit 4, then drives receive LED.
`timescale 1ns/1ns
`default_nettype none
`include "strap_led_map.svh"
module strap_led_pins
  import strap_led_pkg::*;
#(parameter int unsigned HOLD_CYC = `COL_STRETCH_CYC)
(
  // Clock, hardware reset and enable.
  input  wire logic                clock,
  input  wire logic                hardware_reset_n,
  input  wire logic                clk_en,
  // Software reset, which leaves the straps alone.
  input  wire logic                soft_reset,
  // Link status from the PHY core.
  input  wire strap_led_pkg::status_t status,
  // Address field of an incoming management frame.
  input  wire logic [4:0]          frame_addr,
  // Shared pins: order rx, tx, link, col, act from bit 4 down.
  input  wire logic [4:0]          pin_in,
  output logic [4:0]               pin_out,
  output logic [4:0]               pin_oe,
  // Latched address and match result.
  output logic [4:0]               management_address,
  output logic                     addr_match,
  output logic                     strap_valid
);
  import strap_led_pkg::*;

  logic   [4:0] sync1_r;
  logic   [4:0] sync2_r;
  logic   [4:0] sync3_r;
  logic   [4:0] stable_r;
  phase_t       phase_r;
  logic   [4:0] led_on;
  logic   [4:0] led_nxt;
  logic         col_active;
  logic         reset_n;

  assign reset_n = hardware_reset_n;

  // Three stage synchroniser; a level counts once stages two and three agree.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end
    else if (clk_en)
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Filtered strap level, one bit per pin.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      stable_r <= 5'h00;
    else if (clk_en)
    begin
      for (int i = 0; i < `PIN_COUNT; i++)
        if (sync2_r[i] == sync3_r[i])
          stable_r[i] <= sync3_r[i];
    end
  end

  // After release the pins stay inputs until the synchroniser has filled,
  // since the asynchronous reset may not load a port value directly.
  logic [2:0] fill_r;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_r <= ST_RESET;
      fill_r  <= 3'h0;
    end
    else if (clk_en)
    begin
      case (phase_r)
        ST_RESET:
        begin
          fill_r <= fill_r + 3'h1;
          if (fill_r == `FILL_LAST)
            phase_r <= ST_SAMPLE;
        end
        ST_SAMPLE: phase_r <= ST_RUN;
        default:   phase_r <= ST_RUN;
      endcase
    end
  end

  // Strap latch; the soft reset input is deliberately not used here.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      management_address <= 5'h00;
    else if (clk_en && phase_r == ST_SAMPLE)
      management_address <= stable_r;
  end

  // Collision stretcher.
  stretch_timer #(.HOLD_CYC(HOLD_CYC)) u_col
  (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .trigger (status.collision),
    .active  (col_active)
  );

  // LED conditions in pin order.
  always_comb
  begin
    led_on                = 5'h00;
    led_on[`ADDR_BIT_ACT]  = status.rx_active | status.tx_active;
    led_on[`ADDR_BIT_COL]  = col_active;
    led_on[`ADDR_BIT_LINK] = status.link_up;
    led_on[`ADDR_BIT_TX]   = status.tx_active;
    led_on[`ADDR_BIT_RX]   = status.rx_active;
    // An unlit pin shows its own strap level, a lit one the inverse of it.
    led_nxt = led_on ^ management_address;
  end

  // Registered pin drive; enables go high only once running.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_out <= 5'h00;
      pin_oe  <= 5'h00;
    end
    else if (clk_en)
    begin
      pin_out <= (phase_r == ST_RUN) ? led_nxt : 5'h00;
      pin_oe  <= (phase_r == ST_RUN) ? 5'h1f : 5'h00;
    end
  end

  assign strap_valid = (phase_r == ST_RUN);
  assign addr_match  = strap_valid && (frame_addr == management_address);

  // Cycles since the last collision, counted apart from the stretcher so that
  // the hold check below does not merely restate the stretcher's own counter.
  logic [`CNT_W-1:0] col_age_r;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      col_age_r <= '1;
    else if (clk_en)
    begin
      if (status.collision)
        col_age_r <= '0;
      else if (col_age_r != '1)
        col_age_r <= col_age_r + `CNT_W'(1);
    end
  end

  // Address must not change while running, even across soft resets.
  a_addr_hold: assert property (@(posedge clock) disable iff (!reset_n)
    $past(strap_valid) && strap_valid |-> $stable(management_address))
    else $error("address changed after strap sampling");
  // A soft reset leaves every pin an output.
  a_soft_keep: assert property (@(posedge clock) disable iff (!reset_n)
    soft_reset && strap_valid && clk_en |=> strap_valid && (&pin_oe))
    else $error("soft reset released the pins");
  // Pins stay released until sampling is over, and all drive afterwards.
  a_pins_input: assert property (@(posedge clock) disable iff (!reset_n)
    !strap_valid |=> pin_oe == 5'h00)
    else $error("pin driven before sampling");
  a_pins_drive: assert property (@(posedge clock) disable iff (!reset_n)
    strap_valid && clk_en |=> (&pin_oe))
    else $error("pin not driven after sampling");
  // Each LED follows its condition one cycle later, inverted against its strap.
  a_link_led: assert property (@(posedge clock) disable iff (!reset_n)
    strap_valid && clk_en && $past(strap_valid) |=> pin_out[`ADDR_BIT_LINK] ==
    ($past(status.link_up) ^ management_address[`ADDR_BIT_LINK]))
    else $error("link LED level wrong");
  a_act_led: assert property (@(posedge clock) disable iff (!reset_n)
    strap_valid && clk_en |=> pin_out[`ADDR_BIT_ACT] ==
    (($past(status.rx_active) | $past(status.tx_active)) ^
    management_address[`ADDR_BIT_ACT]))
    else $error("activity LED level wrong");
  a_tx_led: assert property (@(posedge clock) disable iff (!reset_n)
    strap_valid && clk_en |=> pin_out[`ADDR_BIT_TX] ==
    ($past(status.tx_active) ^ management_address[`ADDR_BIT_TX]))
    else $error("transmit LED level wrong");
  a_rx_led: assert property (@(posedge clock) disable iff (!reset_n)
    strap_valid && clk_en |=> pin_out[`ADDR_BIT_RX] ==
    ($past(status.rx_active) ^ management_address[`ADDR_BIT_RX]))
    else $error("receive LED level wrong");
  a_col_led: assert property (@(posedge clock) disable iff (!reset_n)
    strap_valid && clk_en |=> pin_out[`ADDR_BIT_COL] ==
    ($past(col_active) ^ management_address[`ADDR_BIT_COL]))
    else $error("collision LED level wrong");
  a_col_start: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && status.collision |=> col_active)
    else $error("collision not stretched");
  a_col_hold: assert property (@(posedge clock) disable iff (!reset_n)
    col_active == (col_age_r < `CNT_W'(HOLD_CYC)))
    else $error("collision LED hold length wrong");
  a_sample_load: assert property (@(posedge clock) disable iff (!reset_n)
    phase_r == ST_SAMPLE && clk_en |=> management_address == $past(stable_r))
    else $error("strap not loaded");
  a_match: assert property (@(posedge clock) disable iff (!reset_n)
    addr_match |-> frame_addr == management_address)
    else $error("bad address match");

  c_run: cover property (@(posedge clock) disable iff (!reset_n) $rose(strap_valid));
  c_col: cover property (@(posedge clock) disable iff (!reset_n) $fell(col_active));
  c_match: cover property (@(posedge clock) disable iff (!reset_n) addr_match);
  c_soft: cover property (@(posedge clock) disable iff (!reset_n) soft_reset && strap_valid);
endmodule : strap_led_pins
`default_nettype wire

// ### rtl/stretch_timer.sv
// Retriggerable pulse stretcher for the collision LED.
`timescale 1ns/1ns
`default_nettype none
`include "strap_led_map.svh"
module stretch_timer #(parameter int unsigned HOLD_CYC = `COL_STRETCH_CYC)
(
  // Clock, reset and enable.
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Trigger and stretched output.
  input  wire logic trigger,
  output logic      active
);
  logic [`CNT_W-1:0] count_r;

  // Each collision reloads the count, so bursts keep the LED lit.
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      count_r <= '0;
    else if (clk_en)
    begin
      if (trigger)
        count_r <= `CNT_W'(HOLD_CYC);
      else if (count_r != '0)
        count_r <= count_r - `CNT_W'(1);
    end
  end

  assign active = (count_r != '0);
endmodule : stretch_timer
`default_nettype wire
